//--- rtl/fft_pkg.sv
package fft_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] ADDR_WIRING   = 8'h50;
    localparam logic [7:0] ADDR_PRI_V    = 8'h51;
    localparam logic [7:0] ADDR_SEC_V    = 8'h52;
    localparam logic [7:0] ADDR_TC       = 8'h53;
    localparam logic [7:0] ADDR_UV_EN    = 8'h58;
    localparam logic [7:0] ADDR_OV_EN    = 8'h59;
    localparam logic [7:0] ADDR_TC_EN    = 8'h5a;
    localparam logic [7:0] ADDR_MISC     = 8'h5c;
    localparam logic [7:0] ADDR_LOG_STAT = 8'h5f;
    localparam logic [7:0] ADDR_INT_STAT = 8'h60;
    localparam logic [7:0] ADDR_INT_CLR  = 8'h61;
    localparam logic [7:0] ADDR_INT_EN   = 8'h62;

    // ************************************************
    // field positions and masks
    // ************************************************
    localparam int         MISC_NOISE_BIT = 6;
    localparam int         MISC_STORE_BIT = 7;
    localparam int         LOG_LOCK_BIT   = 1;
    localparam int         INT_LOG_BIT    = 0;
    localparam int         INT_PRI_BIT    = 1;
    localparam int         INT_WIRE_BIT   = 2;
    localparam logic [7:0] MISC_MASK      = 8'hc0;
    localparam logic [7:0] TC_EN_MASK     = 8'h0f;
    localparam logic [7:0] INT_MASK       = 8'h07;

    // ************************************************
    // reset values and sizes
    // ************************************************
    localparam logic [7:0] RST_LOG_EN = 8'h00;
    localparam logic [7:0] RST_MISC   = 8'h00;
    localparam logic [7:0] RST_INT    = 8'h00;
    localparam int         NUM_CH     = 12;
    localparam int         RES_W      = 10;
    localparam int         LOG_W      = 8;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic [7:0] uv_pri;
        logic [7:0] ov_pri;
        logic [7:0] uv_sec;
        logic [7:0] ov_sec;
        logic [2:0] ot_pri;
        logic [2:0] ot_sec;
        logic       oc_pri;
        logic       oc_sec;
        logic [1:0] rs_short;
        logic [1:0] rs_open;
    } fft_cmp_type;

    typedef struct packed {
        logic [7:0] tc;
        logic [7:0] sec_v;
        logic [7:0] pri_v;
        logic [7:0] wiring;
    } fft_flags_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fft_bus_type;

    // any enabled primary condition present
    function automatic logic log_cond(fft_cmp_type c, logic [7:0] uv_en,
                                      logic [7:0] ov_en, logic [7:0] tc_en);
        log_cond = (|(c.uv_pri & uv_en)) | (|(c.ov_pri & ov_en))
                 | (c.oc_pri & tc_en[0]) | (|(c.ot_pri & tc_en[3:1]));
    endfunction : log_cond

endpackage : fft_pkg

//--- rtl/fft_flag_eval.sv
`timescale 1ns/1ps
`default_nettype none
module fft_flag_eval (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // comparison results
    input  wire logic                  cycle_done,
    input  wire fft_pkg::fft_cmp_type  cmp,
    // flags
    output var  fft_pkg::fft_flags_type flags,
    output logic                       flags_upd
);

    logic [7:0] pri_v;
    logic [7:0] sec_v;

    // ************************************************
    // per input window check
    // ************************************************
    genvar i;
    for (i = 0; i < 8; i++) begin : g_vin
        assign pri_v[i] = cmp.uv_pri[i] | cmp.ov_pri[i];
        assign sec_v[i] = cmp.uv_sec[i] | cmp.ov_sec[i];
    end

    // ************************************************
    // flag update once per converter cycle
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (cycle_done) begin
            flags.wiring <= {4'h0, cmp.rs_open[1], cmp.rs_short[1],
                             cmp.rs_open[0], cmp.rs_short[0]};
            flags.pri_v  <= pri_v;
            flags.sec_v  <= sec_v;
            flags.tc     <= {cmp.oc_sec, cmp.oc_pri, cmp.ot_sec, cmp.ot_pri};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_upd <= 1'b0;
        end else begin
            flags_upd <= cycle_done;
        end
    end

endmodule : fft_flag_eval
`default_nettype wire

//--- rtl/fft_log_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module fft_log_trigger (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // comparison results
    input  wire logic                 cycle_done,
    input  wire fft_pkg::fft_cmp_type cmp,
    // settings
    input  wire logic [7:0]           uv_en,
    input  wire logic [7:0]           ov_en,
    input  wire logic [7:0]           tc_en,
    input  wire logic                 noise_en,
    input  wire logic                 unlock,
    // trigger
    output logic                      trig,
    output logic                      locked
);

    logic cond_now;
    logic prev_cond;
    logic fire;

    assign cond_now = fft_pkg::log_cond(cmp, uv_en, ov_en, tc_en);
    assign fire     = cycle_done && cond_now && (!noise_en || prev_cond)
                    && !locked;

    // ************************************************
    // persistence of the condition
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_cond <= 1'b0;
        end else if (cycle_done) begin
            prev_cond <= cond_now;
        end
    end

    // ************************************************
    // trigger and lock, set wins over unlock
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig   <= 1'b0;
            locked <= 1'b0;
        end else begin
            trig   <= fire;
            locked <= fire || (locked && !unlock);
        end
    end

endmodule : fft_log_trigger
`default_nettype wire

//--- rtl/fft_fault_flag_log.sv
// Functional notes
// - short on remote sensor one sets wiring flag bit 0, sensor two bit 2.
// - open on remote sensor one sets wiring flag bit 1, sensor two bit 3.
// - voltage input n outside primary limits sets primary flag bit n-1.
// - voltage input n outside secondary limits sets secondary flag bit n-1.
// - primary overtemperature of internal, remote one, remote two sets bits 0..2.
// - secondary overtemperature of internal, remote one, remote two sets bits 3..5.
// - primary overcurrent sets bit 6, secondary overcurrent sets bit 7.
// - enabled undervoltage on input n starts a fault log.
// - enabled overvoltage on input n starts a fault log.
// - enable bit 0 lets primary overcurrent start a fault log.
// - enable bits 1..3 let overtemperature of each sensor start a fault log.
// - a log locks further triggers; writing one to lock bit unlocks.
// - noise setting demands the condition on two consecutive converter cycles.
// - a log always stores flags, and result MSBs when storing is enabled.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fft_fault_flag_log (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    // monitor results
    input  wire logic                          cycle_done,
    input  wire fft_pkg::fft_cmp_type          cmp,
    input  wire logic [11:0][9:0]              results,
    // fault log
    output logic                               log_start,
    output var  fft_pkg::fft_flags_type        log_flags,
    output logic [11:0][7:0]                   log_results,
    output logic                               log_results_en,
    output logic                               log_locked,
    // interrupt
    output logic                               irq
);

    // ************************************************
    // declarations
    // ************************************************
    fft_pkg::fft_bus_type   bus;
    fft_pkg::fft_flags_type flags;
    logic                   flags_upd;
    logic                   trig;
    logic                   locked;
    logic [7:0]             uv_en_reg;
    logic [7:0]             ov_en_reg;
    logic [7:0]             tc_en_reg;
    logic [7:0]             misc_reg;
    logic [7:0]             int_stat_reg;
    logic [7:0]             int_stat_next;
    logic [7:0]             int_en_reg;
    logic [7:0]             int_clr;
    logic [7:0]             int_event;
    logic [7:0]             rd_value;
    logic                   unlock;
    logic                   noise_en;
    logic                   store_en;

    assign bus      = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign noise_en = misc_reg[fft_pkg::MISC_NOISE_BIT];
    assign store_en = misc_reg[fft_pkg::MISC_STORE_BIT];
    assign unlock   = bus.wr && (bus.addr == fft_pkg::ADDR_LOG_STAT)
                    && bus.wdata[fft_pkg::LOG_LOCK_BIT];

    // ************************************************
    // flag evaluation
    // ************************************************
    fft_flag_eval u_flag_eval (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .cycle_done (cycle_done),
        .cmp        (cmp),
        .flags      (flags),
        .flags_upd  (flags_upd)
    );

    // ************************************************
    // log trigger
    // ************************************************
    fft_log_trigger u_log_trigger (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .cycle_done (cycle_done),
        .cmp        (cmp),
        .uv_en      (uv_en_reg),
        .ov_en      (ov_en_reg),
        .tc_en      (tc_en_reg),
        .noise_en   (noise_en),
        .unlock     (unlock),
        .trig       (trig),
        .locked     (locked)
    );

    // ************************************************
    // log enable registers
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            uv_en_reg <= fft_pkg::RST_LOG_EN;
            ov_en_reg <= fft_pkg::RST_LOG_EN;
            tc_en_reg <= fft_pkg::RST_LOG_EN;
        end else if (bus.wr) begin
            case (bus.addr)
                fft_pkg::ADDR_UV_EN: begin
                    uv_en_reg <= bus.wdata;
                end
                fft_pkg::ADDR_OV_EN: begin
                    ov_en_reg <= bus.wdata;
                end
                fft_pkg::ADDR_TC_EN: begin
                    tc_en_reg <= bus.wdata & fft_pkg::TC_EN_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************
    // settings register
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            misc_reg <= fft_pkg::RST_MISC;
        end else if (bus.wr && (bus.addr == fft_pkg::ADDR_MISC)) begin
            misc_reg <= bus.wdata & fft_pkg::MISC_MASK;
        end
    end

    // ************************************************
    // interrupt enable
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_en_reg <= fft_pkg::RST_INT;
        end else if (bus.wr && (bus.addr == fft_pkg::ADDR_INT_EN)) begin
            int_en_reg <= bus.wdata & fft_pkg::INT_MASK;
        end
    end

    // ************************************************
    // interrupt status, set wins over clear
    // ************************************************
    always_comb begin
        int_event = 8'h00;
        int_event[fft_pkg::INT_LOG_BIT]  = trig;
        int_event[fft_pkg::INT_PRI_BIT]  = flags_upd
            && ((|flags.pri_v) || (|flags.tc[2:0]) || flags.tc[6]);
        int_event[fft_pkg::INT_WIRE_BIT] = flags_upd && (|flags.wiring);
        int_clr = 8'h00;
        if (bus.wr && (bus.addr == fft_pkg::ADDR_INT_CLR)) begin
            int_clr = bus.wdata;
        end
        int_stat_next = ((int_stat_reg & ~int_clr) | int_event) & fft_pkg::INT_MASK;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_stat_reg <= fft_pkg::RST_INT;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_next & int_en_reg);
        end
    end

    // ************************************************
    // read path
    // ************************************************
    always_comb begin
        case (bus.addr)
            fft_pkg::ADDR_WIRING:   rd_value = {4'h0, flags.wiring[3:0]};
            fft_pkg::ADDR_PRI_V:    rd_value = flags.pri_v;
            fft_pkg::ADDR_SEC_V:    rd_value = flags.sec_v;
            fft_pkg::ADDR_TC:       rd_value = flags.tc;
            fft_pkg::ADDR_UV_EN:    rd_value = uv_en_reg;
            fft_pkg::ADDR_OV_EN:    rd_value = ov_en_reg;
            fft_pkg::ADDR_TC_EN:    rd_value = tc_en_reg;
            fft_pkg::ADDR_MISC:     rd_value = misc_reg;
            fft_pkg::ADDR_LOG_STAT: rd_value = {6'h00, locked, 1'b0};
            fft_pkg::ADDR_INT_STAT: rd_value = int_stat_reg;
            fft_pkg::ADDR_INT_EN:   rd_value = int_en_reg;
            default:                rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (bus.rd) begin
            reg_rdata <= rd_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************
    // fault log snapshot
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            log_start <= 1'b0;
            log_locked <= 1'b0;
        end else begin
            log_start <= trig;
            log_locked <= locked;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            log_flags      <= '0;
            log_results    <= '0;
            log_results_en <= 1'b0;
        end else if (trig) begin
            log_flags      <= flags;
            log_results_en <= store_en;
            for (int c = 0; c < fft_pkg::NUM_CH; c++) begin
                log_results[c] <= store_en ? results[c][9:2] : 8'h00;
            end
        end
    end

    // ************************************************
    // assertion helpers
    // ************************************************
    logic last_cond_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_cond_reg <= 1'b0;
        end else if (cycle_done) begin
            last_cond_reg <= fft_pkg::log_cond(cmp, uv_en_reg, ov_en_reg, tc_en_reg);
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_fire_seen;
        cycle_done && !locked && !noise_en
            && fft_pkg::log_cond(cmp, uv_en_reg, ov_en_reg, tc_en_reg);
    endsequence

    sequence s_pair_seen;
        cycle_done && !locked && noise_en && last_cond_reg
            && fft_pkg::log_cond(cmp, uv_en_reg, ov_en_reg, tc_en_reg);
    endsequence

    sequence s_start_out;
        ##1 trig ##1 (log_start && log_locked);
    endsequence

    a_wiring_flags: assert property (
        flags_upd |-> flags.wiring == {4'h0, $past(cmp.rs_open[1]),
            $past(cmp.rs_short[1]), $past(cmp.rs_open[0]), $past(cmp.rs_short[0])}
    ) else $error("wiring flags wrong");

    a_primary_volt: assert property (
        flags_upd |-> flags.pri_v == ($past(cmp.uv_pri) | $past(cmp.ov_pri))
    ) else $error("primary voltage flags wrong");

    a_secondary_volt: assert property (
        flags_upd |-> flags.sec_v == ($past(cmp.uv_sec) | $past(cmp.ov_sec))
    ) else $error("secondary voltage flags wrong");

    a_temp_cur_flags: assert property (
        flags_upd |-> flags.tc == {$past(cmp.oc_sec), $past(cmp.oc_pri),
            $past(cmp.ot_sec), $past(cmp.ot_pri)}
    ) else $error("temperature or current flags wrong");

    a_log_fires: assert property (
        s_fire_seen |-> s_start_out
    ) else $error("enabled condition did not start a log");

    a_noise_fires: assert property (
        s_pair_seen |-> s_start_out
    ) else $error("persistent condition did not start a log");

    a_lock_ignores: assert property (
        (locked && log_locked) |-> ##2 !log_start
    ) else $error("log started while locked");

    a_lock_holds: assert property (
        (locked && !unlock) |=> locked
    ) else $error("lock dropped without unlock");

    a_unlock_write: assert property (
        (unlock && !trig && locked) |=> !locked ##1 !log_locked
    ) else $error("unlock write ignored");

    a_noise_pair: assert property (
        (cycle_done && noise_en && !last_cond_reg) |=> !trig
    ) else $error("log started on a single cycle");

    a_snapshot: assert property (
        trig |=> log_start && (log_flags == $past(flags))
            && (log_results_en == $past(store_en))
    ) else $error("log snapshot wrong");

    a_results_off: assert property (
        (trig && !store_en) |=> (log_results == '0) && !log_results_en
    ) else $error("results stored while storing disabled");

    a_tc_en_unused: assert property (
        tc_en_reg[7:4] == 4'h0
    ) else $error("unused enable bits not zero");

    a_unused_zero: assert property (
        (bus.rd && bus.addr == fft_pkg::ADDR_WIRING) |=> reg_rdata[7:4] == 4'h0
    ) else $error("unused bits not zero");

    a_lock_read: assert property (
        (bus.rd && bus.addr == fft_pkg::ADDR_LOG_STAT)
            |=> reg_rdata == {6'h00, $past(locked), 1'b0}
    ) else $error("lock status read wrong");

    a_eval_once: assert property (
        flags_upd == $past(cycle_done)
    ) else $error("flags not evaluated per cycle");

    a_irq_level: assert property (
        (|(int_stat_reg & int_en_reg)) |-> ##[0:1] irq
    ) else $error("interrupt not raised");

endmodule : fft_fault_flag_log
`default_nettype wire

//--- sim/fft_fault_flag_log_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fft_fault_flag_log_bench;

    // ************************************************
    // design ports
    // ************************************************
    logic                 mclk           = 1'b0;
    logic                 rst_n          = 1'b0;
    logic [7:0]           reg_addr       = 8'h00;
    logic [7:0]           reg_wdata      = 8'h00;
    logic                 reg_wr         = 1'b0;
    logic                 reg_rd         = 1'b0;
    logic [7:0]           reg_rdata;
    logic                 cycle_done     = 1'b0;
    fft_pkg::fft_cmp_type cmp            = '0;
    logic [11:0][9:0]     results        = '0;
    logic                 log_start;
    fft_pkg::fft_flags_type log_flags;
    logic [11:0][7:0]     log_results;
    logic                 log_results_en;
    logic                 log_locked;
    logic                 irq;

    // ************************************************
    // bench state
    // ************************************************
    int                     err_count = 0;
    int                     tests_run = 0;
    int                     n;
    fft_pkg::fft_flags_type lf;
    logic [11:0][7:0]       lr;
    logic                   le;
    logic [11:0][7:0]       er;
    fft_pkg::fft_flags_type ef;
    fft_pkg::fft_cmp_type   c;
    logic [63:0]            rv;

    fft_fault_flag_log dut_u (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .cycle_done     (cycle_done),
        .cmp            (cmp),
        .results        (results),
        .log_start      (log_start),
        .log_flags      (log_flags),
        .log_results    (log_results),
        .log_results_en (log_results_en),
        .log_locked     (log_locked),
        .irq            (irq)
    );

    initial begin
        forever #4 mclk = ~mclk;
    end

    // ************************************************
    // helpers
    // ************************************************
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask : rd

    // one converter cycle; counts log events seen afterwards
    task automatic conv(input fft_pkg::fft_cmp_type cv, output int cnt);
        cnt = 0;
        @(posedge mclk);
        cmp        <= cv;
        cycle_done <= 1'b1;
        @(posedge mclk);
        cycle_done <= 1'b0;
        repeat (5) begin
            @(posedge mclk);
            #1;
            if (log_start === 1'b1) begin
                cnt++;
                lf = log_flags;
                lr = log_results;
                le = log_results_en;
            end
        end
    endtask : conv

    // expected flag registers from comparison results
    function automatic fft_pkg::fft_flags_type flags_of(input fft_pkg::fft_cmp_type cv);
        flags_of.wiring = {4'h0, cv.rs_open[1], cv.rs_short[1], cv.rs_open[0], cv.rs_short[0]};
        flags_of.pri_v  = cv.uv_pri | cv.ov_pri;
        flags_of.sec_v  = cv.uv_sec | cv.ov_sec;
        flags_of.tc     = {cv.oc_sec, cv.oc_pri, cv.ot_sec, cv.ot_pri};
    endfunction : flags_of

    // single primary log source: 0..7 uv, 8..15 ov, 16 oc, 17..19 ot
    function automatic fft_pkg::fft_cmp_type src_cmp(input int i);
        src_cmp = '0;
        if (i < 8) src_cmp.uv_pri[i] = 1'b1;
        else if (i < 16) src_cmp.ov_pri[i-8] = 1'b1;
        else if (i == 16) src_cmp.oc_pri = 1'b1;
        else src_cmp.ot_pri[i-17] = 1'b1;
    endfunction : src_cmp

    initial begin
        #(20000 * 8);
        err_count++;
        end_sim();
    end

    // ************************************************
    // tests
    // ************************************************
    initial begin
        void'($urandom(32'h41239672));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;

        rd(fft_pkg::ADDR_TC_EN, 8'h00, "tc_en_reset");
        rd(8'h55, 8'h00, "unmapped");
        wr(fft_pkg::ADDR_TC_EN, 8'hff);
        rd(fft_pkg::ADDR_TC_EN, 8'h0f, "tc_en_unused");
        wr(fft_pkg::ADDR_WIRING, 8'hff);
        rd(fft_pkg::ADDR_WIRING, 8'h00, "wiring_ro");
        wr(fft_pkg::ADDR_TC_EN, 8'h00);
        $display("test registers done");

        for (int k = 0; k < 12; k++) begin
            rv = {$urandom(), $urandom()};
            c  = rv[43:0];
            ef = flags_of(c);
            conv(c, n);
            rd(fft_pkg::ADDR_WIRING, ef.wiring, "wiring");
            rd(fft_pkg::ADDR_PRI_V, ef.pri_v, "pri_v");
            rd(fft_pkg::ADDR_SEC_V, ef.sec_v, "sec_v");
            rd(fft_pkg::ADDR_TC, ef.tc, "tc");
        end
        $display("test flags done");

        for (int i = 0; i < 20; i++) begin
            for (int ch = 0; ch < 12; ch++) begin
                results[ch] <= 10'($urandom());
            end
            wr(fft_pkg::ADDR_UV_EN, (i < 8) ? 8'h01 << i : 8'h00);
            wr(fft_pkg::ADDR_OV_EN, (i >= 8 && i < 16) ? 8'h01 << (i - 8) : 8'h00);
            wr(fft_pkg::ADDR_TC_EN, (i >= 16) ? 8'h01 << (i - 16) : 8'h00);
            wr(fft_pkg::ADDR_MISC, i[0] ? 8'h80 : 8'h00);
            conv(~src_cmp(i), n);
            chk("log_disabled", n, 0);
            conv(src_cmp(i), n);
            ef = flags_of(src_cmp(i));
            for (int ch = 0; ch < 12; ch++) begin
                er[ch] = i[0] ? results[ch][9:2] : 8'h00;
            end
            chk("log_count", n, 1);
            chk("log_flags", lf, ef);
            chk("log_res_en", le, i[0]);
            chk("log_results", lr, er);
            chk("locked", log_locked, 1'b1);
            rd(fft_pkg::ADDR_LOG_STAT, 8'h02, "lock_stat");
            conv(src_cmp(i), n);
            chk("log_while_locked", n, 0);
            wr(fft_pkg::ADDR_LOG_STAT, 8'h02);
            rd(fft_pkg::ADDR_LOG_STAT, 8'h00, "unlock_stat");
        end
        $display("test log sources done");

        wr(fft_pkg::ADDR_MISC, 8'h40);
        wr(fft_pkg::ADDR_UV_EN, 8'h01);
        wr(fft_pkg::ADDR_OV_EN, 8'h00);
        wr(fft_pkg::ADDR_TC_EN, 8'h00);
        conv('0, n);
        conv(src_cmp(0), n);
        chk("noise_first", n, 0);
        conv(src_cmp(0), n);
        chk("noise_second", n, 1);
        wr(fft_pkg::ADDR_LOG_STAT, 8'h02);
        conv('0, n);
        conv(src_cmp(0), n);
        conv('0, n);
        conv(src_cmp(0), n);
        chk("noise_gap", n, 0);
        $display("test noise done");

        wr(fft_pkg::ADDR_MISC, 8'h00);
        wr(fft_pkg::ADDR_UV_EN, 8'h08);
        wr(fft_pkg::ADDR_INT_EN, 8'h00);
        wr(fft_pkg::ADDR_INT_CLR, 8'h07);
        c = src_cmp(3);
        c.rs_open[0] = 1'b1;
        conv(c, n);
        chk("int_log", n, 1);
        conv('0, n);
        rd(fft_pkg::ADDR_INT_STAT, 8'h07, "int_stat");
        chk("irq_masked", irq, 1'b0);
        wr(fft_pkg::ADDR_INT_EN, 8'h04);
        rd(fft_pkg::ADDR_INT_EN, 8'h04, "int_en");
        chk("irq_on", irq, 1'b1);
        wr(fft_pkg::ADDR_INT_CLR, 8'h04);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_cleared", irq, 1'b0);
        rd(fft_pkg::ADDR_INT_STAT, 8'h03, "int_stat_clr");
        $display("test interrupt done");
        end_sim();
    end

endmodule : fft_fault_flag_log_bench
`default_nettype wire
